/* hw/gii_instrument_interface.sv */
`timescale 1ns/100ps
`default_nettype none
`include "gii_consts.svh"
module gii_instrument_interface (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// bus management lines, low true, received only
	input wire logic atn_b,
	input wire logic ifc_b,
	input wire logic ren_b,
	// data lines
	input wire logic [7:0] dio_b_i,
	output logic [7:0] dio_b_o,
	output logic dio_b_oe,
	// handshake and end lines
	input wire logic dav_b_i,
	output logic dav_b_o,
	output logic dav_b_oe,
	input wire logic nrfd_b_i,
	output logic nrfd_b_o,
	output logic nrfd_b_oe,
	input wire logic ndac_b_i,
	output logic ndac_b_o,
	output logic ndac_b_oe,
	input wire logic eoi_b_i,
	output logic eoi_b_o,
	output logic eoi_b_oe,
	// service request line
	output logic srq_b_o,
	output logic srq_b_oe,
	// received bytes toward the command parser
	output logic [7:0] rx_data,
	output logic rx_end,
	output logic rx_valid,
	input wire logic rx_ready,
	// reply bytes from the command parser
	input wire logic [7:0] tx_data,
	input wire logic tx_end,
	input wire logic tx_valid,
	output logic tx_ready,
	// service request conditions
	input wire logic [7:0] status_byte,
	input wire logic [7:0] srq_enable,
	// configuration from the command parser
	input wire logic addr_wr,
	input wire logic [4:0] addr_value,
	input wire logic clear_mode_wr,
	input wire logic clear_mode_zero,
	input wire logic trg_cmd,
	// instrument state and events
	output logic [4:0] bus_addr,
	output logic remote,
	output logic analog_select,
	output logic talker,
	output logic listener,
	output logic serial_poll,
	output logic dev_clear,
	output logic zero_output,
	output logic trigger
);
	import gii_pkg::*;

	// classify a byte received under attention
	function automatic gii_cmd_t gii_decode(
		input logic [6:0] c,
		input logic [4:0] a
	);
		gii_cmd_t r;
		r = CMD_NONE;
		if (c == `GII_CMD_UNL) begin
			r = CMD_UNL;
		end else if (c == `GII_CMD_UNT) begin
			r = CMD_UNT;
		end else if (c == {`GII_LAG_GROUP, a}) begin
			r = CMD_MLA;
		end else if (c == {`GII_TAG_GROUP, a}) begin
			r = CMD_MTA;
		end else if (c[6:5] == `GII_TAG_GROUP) begin
			r = CMD_OTA;
		end else if (c == `GII_CMD_DCL) begin
			r = CMD_DCL;
		end else if (c == `GII_CMD_SDC) begin
			r = CMD_SDC;
		end else if (c == `GII_CMD_GET) begin
			r = CMD_GET;
		end else if (c == `GII_CMD_SPE) begin
			r = CMD_SPE;
		end else if (c == `GII_CMD_SPD) begin
			r = CMD_SPD;
		end else if (c == `GII_CMD_GTL) begin
			r = CMD_GTL;
		end
		return r;
	endfunction : gii_decode

	// reset release through two flip-flops
	logic rst_s1_r, rst_sync_b;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_r <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_sync_b <= rst_s1_r;
		end
	end

	logic atn, ifc, ren;
	assign atn = !atn_b;
	assign ifc = !ifc_b;
	assign ren = !ren_b;

	logic talk_r, talk_nxt, listen_r, listen_nxt;
	logic spoll_r, spoll_nxt, remote_r, remote_nxt;
	logic [4:0] addr_r, addr_nxt;
	gii_clear_mode_t mode_r, mode_nxt;
	logic srq_pend_r, srq_pend_nxt, rsv_prev_r;
	logic clear_r, clear_nxt, zero_r, zero_nxt, trig_r, trig_nxt;
	logic acc_strobe, acc_end, acc_cmd, src_ready;
	logic [7:0] acc_data, src_data;
	logic cmd_in, rsv, rsv_rise, src_en, src_valid, src_end, spoll_take;
	gii_cmd_t cmd_code;

	// rqs is our own bit and never requests service on its own
	assign rsv = |(status_byte & srq_enable & ~`GII_RQS_MASK);
	assign rsv_rise = rsv && !rsv_prev_r;
	assign cmd_in = acc_strobe && acc_cmd;
	assign cmd_code = gii_decode(acc_data[6:0], addr_r);

	// talker: reply bytes, or the status byte while serial poll is on
	assign src_en = talk_r && !atn;
	assign src_valid = spoll_r || tx_valid;
	assign src_data = spoll_r ?
		{status_byte[7], srq_pend_r, status_byte[5:0]} : tx_data;
	assign src_end = spoll_r ? 1'b0 : tx_end;
	assign tx_ready = src_ready && !spoll_r;
	assign spoll_take = src_ready && spoll_r;

	// listener data goes out straight from the capture flops
	assign rx_data = acc_data;
	assign rx_end = acc_end;
	assign rx_valid = acc_strobe && !acc_cmd && listen_r;

	always_comb begin
		talk_nxt = talk_r;
		listen_nxt = listen_r;
		spoll_nxt = spoll_r;
		remote_nxt = remote_r;
		addr_nxt = addr_r;
		mode_nxt = mode_r;
		clear_nxt = 1'b0;
		trig_nxt = trg_cmd;
		if (addr_wr) begin
			addr_nxt = addr_value;
		end
		if (clear_mode_wr) begin
			mode_nxt = clear_mode_zero ? CLEAR_ZEROES_OUTPUT_MODE :
				CLEAR_KEEPS_OUTPUT_MODE;
		end
		if (cmd_in) begin
			unique case (cmd_code)
				CMD_MLA: begin
					listen_nxt = 1'b1;
					talk_nxt = 1'b0;
				end
				CMD_MTA: begin
					talk_nxt = 1'b1;
					listen_nxt = 1'b0;
				end
				CMD_OTA: talk_nxt = 1'b0;
				CMD_UNT: talk_nxt = 1'b0;
				CMD_UNL: listen_nxt = 1'b0;
				CMD_DCL: clear_nxt = 1'b1;
				CMD_SDC: clear_nxt = listen_r;
				CMD_GET: trig_nxt = trig_nxt || listen_r;
				CMD_SPE: spoll_nxt = 1'b1;
				CMD_SPD: spoll_nxt = 1'b0;
				CMD_GTL: if (listen_r) begin
					remote_nxt = 1'b0;
				end
				CMD_NONE: ;
			endcase
		end
		if (rx_valid && ren) begin
			remote_nxt = 1'b1;
		end
		if (!ren) begin
			remote_nxt = 1'b0;
		end
		// zero only in the zeroing mode, output untouched otherwise
		zero_nxt = clear_nxt && mode_r == CLEAR_ZEROES_OUTPUT_MODE;
		if (ifc) begin
			talk_nxt = 1'b0;
			listen_nxt = 1'b0;
			spoll_nxt = 1'b0;
		end
	end

	// a new condition wins over the poll that would clear the request
	always_comb begin
		srq_pend_nxt = srq_pend_r;
		if (!rsv || spoll_take) begin
			srq_pend_nxt = 1'b0;
		end
		if (rsv_rise) begin
			srq_pend_nxt = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			talk_r <= 1'b0;
			listen_r <= 1'b0;
			spoll_r <= 1'b0;
			remote_r <= 1'b0;
			addr_r <= `GII_ADDR_DEFAULT;
			mode_r <= CLEAR_KEEPS_OUTPUT_MODE;
			clear_r <= 1'b0;
			zero_r <= 1'b0;
			trig_r <= 1'b0;
			srq_pend_r <= 1'b0;
			rsv_prev_r <= 1'b0;
		end else begin
			talk_r <= talk_nxt;
			listen_r <= listen_nxt;
			spoll_r <= spoll_nxt;
			remote_r <= remote_nxt;
			addr_r <= addr_nxt;
			mode_r <= mode_nxt;
			clear_r <= clear_nxt;
			zero_r <= zero_nxt;
			trig_r <= trig_nxt;
			srq_pend_r <= srq_pend_nxt;
			rsv_prev_r <= rsv;
		end
	end

	// atn, ifc and ren are never driven, and no parallel poll answer
	gii_handshake gii_handshake_inst (
		.clock(clock),
		.rst_sync_b(rst_sync_b),
		.atn(atn),
		.dio_b_i(dio_b_i),
		.dio_b_o(dio_b_o),
		.dio_b_oe(dio_b_oe),
		.dav_b_i(dav_b_i),
		.dav_b_o(dav_b_o),
		.dav_b_oe(dav_b_oe),
		.nrfd_b_i(nrfd_b_i),
		.nrfd_b_o(nrfd_b_o),
		.nrfd_b_oe(nrfd_b_oe),
		.ndac_b_i(ndac_b_i),
		.ndac_b_o(ndac_b_o),
		.ndac_b_oe(ndac_b_oe),
		.eoi_b_i(eoi_b_i),
		.eoi_b_o(eoi_b_o),
		.eoi_b_oe(eoi_b_oe),
		.src_en(src_en),
		.src_valid(src_valid),
		.src_data(src_data),
		.src_end(src_end),
		.src_ready(src_ready),
		.acc_en(atn || listen_r),
		.acc_hold(!atn && !rx_ready),
		.acc_strobe(acc_strobe),
		.acc_data(acc_data),
		.acc_end(acc_end),
		.acc_cmd(acc_cmd)
	);

	assign srq_b_o = 1'b0;
	assign srq_b_oe = srq_pend_r;
	assign bus_addr = addr_r;
	assign remote = remote_r;
	assign analog_select = !remote_r;
	assign talker = talk_r;
	assign listener = listen_r;
	assign serial_poll = spoll_r;
	assign dev_clear = clear_r;
	assign zero_output = zero_r;
	assign trigger = trig_r;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_sync_b);

	a_mla_drops_talk: assert property (
		cmd_in && cmd_code == CMD_MLA && !ifc |=> listener && !talker
	) else $error("listen address did not drop talker");
	a_mta_drops_listen: assert property (
		cmd_in && cmd_code == CMD_MTA && !ifc |=> talker && !listener
	) else $error("talk address did not drop listener");
	a_srq_on_enabled: assert property (
		rsv_rise |=> srq_b_oe ##1 (srq_b_oe || !$past(rsv) || $past(spoll_take))
	) else $error("enabled condition did not raise service request");
	a_local_analog: assert property (
		!ren |=> analog_select && !remote
	) else $error("analog inputs not selected in local");
	a_first_cmd_remote: assert property (
		rx_valid && ren && !ren_b |=> remote && !analog_select
	) else $error("received command did not enter remote");
	a_clear_accepted: assert property (
		cmd_in && (cmd_code == CMD_DCL || (cmd_code == CMD_SDC && listener))
		|=> dev_clear ##1 !dev_clear
	) else $error("device clear not reported as one pulse");
	a_trigger_seen: assert property (
		trg_cmd || (cmd_in && cmd_code == CMD_GET && listener) |=> trigger
	) else $error("trigger event lost");
	a_addr_default: assert property (
		$rose(rst_sync_b) |-> bus_addr == `GII_ADDR_DEFAULT
	) else $error("bus address not default after reset");
	a_addr_update: assert property (
		addr_wr |=> bus_addr == $past(addr_value)
	) else $error("bus address not updated");
	a_clear_zeroes: assert property (
		dev_clear && $past(mode_r) == CLEAR_ZEROES_OUTPUT_MODE |-> zero_output
	) else $error("zeroing clear did not zero output");
	a_clear_keeps: assert property (
		$past(mode_r) == CLEAR_KEEPS_OUTPUT_MODE |-> !zero_output
	) else $error("keeping clear touched output");
	a_mode_default: assert property (
		$rose(rst_sync_b) |-> mode_r == CLEAR_KEEPS_OUTPUT_MODE
	) else $error("clear mode not keeping after reset");
	a_no_poll_answer: assert property (
		eoi_b_oe |-> !atn && talker
	) else $error("end line driven under attention");

	c_talk_byte: cover property ($fell(dav_b_oe) && !spoll_r);
	c_listen_byte: cover property (rx_valid && rx_end);
	c_serial_poll: cover property (spoll_take && srq_pend_r);
	c_clear_zero: cover property (dev_clear && zero_output);
endmodule : gii_instrument_interface
`default_nettype wire

/* hw/gii_consts.svh */
`ifndef GII_CONSTS_SVH
`define GII_CONSTS_SVH

// timing
`define GII_CLK_NS 10
`define GII_SETTLE_NS 500
`define GII_SETTLE_CYC ((`GII_SETTLE_NS + `GII_CLK_NS - 1) / `GII_CLK_NS)
`define GII_CNT_W 6

// addressing and reset values
`define GII_ADDR_DEFAULT 5'h06
`define GII_LAG_GROUP 2'h1
`define GII_TAG_GROUP 2'h2

// bus command codes, seven bits
`define GII_CMD_GTL 7'h01
`define GII_CMD_SDC 7'h04
`define GII_CMD_GET 7'h08
`define GII_CMD_DCL 7'h14
`define GII_CMD_SPE 7'h18
`define GII_CMD_SPD 7'h19
`define GII_CMD_UNL 7'h3F
`define GII_CMD_UNT 7'h5F

// status byte
`define GII_RQS_BIT 6
`define GII_RQS_MASK 8'h40
`endif

/* hw/gii_pkg.sv */
`default_nettype none
package gii_pkg;
	typedef enum logic [1:0] {AH_IDLE, AH_READY, AH_ACCEPT} gii_ah_state_t;
	typedef enum logic [1:0] {
		SH_IDLE, SH_SETTLE, SH_WAIT, SH_DAV
	} gii_sh_state_t;
	typedef enum logic [3:0] {
		CMD_NONE, CMD_MLA, CMD_MTA, CMD_OTA, CMD_UNL, CMD_UNT,
		CMD_DCL, CMD_SDC, CMD_GET, CMD_SPE, CMD_SPD, CMD_GTL
	} gii_cmd_t;
	typedef enum logic {
		CLEAR_KEEPS_OUTPUT_MODE, CLEAR_ZEROES_OUTPUT_MODE
	} gii_clear_mode_t;
endpackage : gii_pkg
`default_nettype wire

/* hw/gii_handshake.sv */
`timescale 1ns/100ps
`default_nettype none
`include "gii_consts.svh"
module gii_handshake (
	// clock and reset
	input wire logic clock,
	input wire logic rst_sync_b,
	// bus lines, low true, except atn which is high true
	input wire logic atn,
	input wire logic [7:0] dio_b_i,
	output logic [7:0] dio_b_o,
	output logic dio_b_oe,
	input wire logic dav_b_i,
	output logic dav_b_o,
	output logic dav_b_oe,
	input wire logic nrfd_b_i,
	output logic nrfd_b_o,
	output logic nrfd_b_oe,
	input wire logic ndac_b_i,
	output logic ndac_b_o,
	output logic ndac_b_oe,
	input wire logic eoi_b_i,
	output logic eoi_b_o,
	output logic eoi_b_oe,
	// source side
	input wire logic src_en,
	input wire logic src_valid,
	input wire logic [7:0] src_data,
	input wire logic src_end,
	output logic src_ready,
	// acceptor side
	input wire logic acc_en,
	input wire logic acc_hold,
	output logic acc_strobe,
	output logic [7:0] acc_data,
	output logic acc_end,
	output logic acc_cmd
);
	import gii_pkg::*;

	gii_sh_state_t sh_st_r, sh_st_nxt;
	logic [`GII_CNT_W-1:0] sh_cnt_r, sh_cnt_nxt;
	logic [7:0] dio_r, dio_nxt;
	logic end_r, end_nxt;
	gii_ah_state_t ah_st_r, ah_st_nxt;
	logic [7:0] acc_data_nxt;
	logic acc_end_nxt, acc_cmd_nxt, acc_strobe_nxt;

	// source handshake
	always_comb begin
		sh_st_nxt = sh_st_r;
		sh_cnt_nxt = sh_cnt_r;
		dio_nxt = dio_r;
		end_nxt = end_r;
		if (!src_en) begin
			sh_st_nxt = SH_IDLE;
		end else begin
			unique case (sh_st_r)
				SH_IDLE: if (src_valid) begin
					sh_st_nxt = SH_SETTLE;
					dio_nxt = ~src_data;
					end_nxt = src_end;
					sh_cnt_nxt = `GII_CNT_W'(`GII_SETTLE_CYC - 1);
				end
				SH_SETTLE: if (sh_cnt_r == '0) begin
					sh_st_nxt = SH_WAIT;
				end else begin
					sh_cnt_nxt = sh_cnt_r - 1'b1;
				end
				SH_WAIT: if (nrfd_b_i) begin
					sh_st_nxt = SH_DAV;
				end
				SH_DAV: if (ndac_b_i) begin
					sh_st_nxt = SH_IDLE;
				end
			endcase
		end
	end

	// acceptor handshake
	always_comb begin
		ah_st_nxt = ah_st_r;
		acc_data_nxt = acc_data;
		acc_end_nxt = acc_end;
		acc_cmd_nxt = acc_cmd;
		acc_strobe_nxt = 1'b0;
		if (!acc_en) begin
			ah_st_nxt = AH_IDLE;
		end else begin
			unique case (ah_st_r)
				AH_IDLE: ah_st_nxt = AH_READY;
				AH_READY: if (!dav_b_i && !acc_hold) begin
					ah_st_nxt = AH_ACCEPT;
					acc_data_nxt = ~dio_b_i;
					acc_end_nxt = !eoi_b_i;
					acc_cmd_nxt = atn;
					acc_strobe_nxt = 1'b1;
				end
				AH_ACCEPT: if (dav_b_i) begin
					ah_st_nxt = AH_READY;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			sh_st_r <= SH_IDLE;
			sh_cnt_r <= '0;
			dio_r <= 8'hFF;
			end_r <= 1'b0;
			ah_st_r <= AH_IDLE;
			acc_data <= 8'h00;
			acc_end <= 1'b0;
			acc_cmd <= 1'b0;
			acc_strobe <= 1'b0;
		end else begin
			sh_st_r <= sh_st_nxt;
			sh_cnt_r <= sh_cnt_nxt;
			dio_r <= dio_nxt;
			end_r <= end_nxt;
			ah_st_r <= ah_st_nxt;
			acc_data <= acc_data_nxt;
			acc_end <= acc_end_nxt;
			acc_cmd <= acc_cmd_nxt;
			acc_strobe <= acc_strobe_nxt;
		end
	end

	// handshake and end lines are only pulled low; gating by src_en keeps eoi off under atn
	assign src_ready = src_en && sh_st_r == SH_IDLE;
	assign dio_b_o = dio_r;
	assign dio_b_oe = src_en && sh_st_r != SH_IDLE;
	assign dav_b_o = 1'b0;
	assign dav_b_oe = src_en && sh_st_r == SH_DAV;
	assign eoi_b_o = 1'b0;
	assign eoi_b_oe = dio_b_oe && end_r;
	assign nrfd_b_o = 1'b0;
	assign nrfd_b_oe = acc_en && !(ah_st_r == AH_READY && !acc_hold);
	assign ndac_b_o = 1'b0;
	assign ndac_b_oe = acc_en && ah_st_r != AH_ACCEPT;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_sync_b);

	a_dav_after_rfd: assert property (
		$rose(dav_b_oe) |-> $past(nrfd_b_i)
	) else $error("data valid asserted before ready for data");
	a_dav_data_stable: assert property (
		dav_b_oe && $past(dav_b_oe) |-> $stable(dio_b_o)
	) else $error("data changed while data valid asserted");
	a_dav_settled: assert property (
		$rose(dav_b_oe) |-> $past(dio_b_oe, `GII_SETTLE_CYC)
	) else $error("data valid asserted before settle time");
	a_accept_not_ready: assert property (
		acc_strobe && acc_en |-> nrfd_b_oe && !ndac_b_oe
	) else $error("acceptor ready again before data valid fell");
endmodule : gii_handshake
`default_nettype wire

/* verif/gii_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module gii_host_model (
	// clock
	input wire logic clock,
	// wire levels seen on the bus
	input wire logic [7:0] dio_w,
	input wire logic dav_w,
	input wire logic nrfd_w,
	input wire logic ndac_w,
	// lines pulled low by the controller
	output logic atn_b,
	output logic [7:0] h_dio_oe,
	output logic h_dav_oe,
	output logic h_nrfd_oe,
	output logic h_ndac_oe,
	output logic h_eoi_oe
);
	int lag;
	initial begin
		atn_b = 1'b1;
		h_dio_oe = 8'h00;
		h_dav_oe = 1'b0;
		h_nrfd_oe = 1'b0;
		h_ndac_oe = 1'b0;
		h_eoi_oe = 1'b0;
		lag = 0;
	end
	function automatic logic line(input int sel);
		case (sel)
			0: return dav_w;
			1: return nrfd_w;
			default: return ndac_w;
		endcase
	endfunction : line
	task automatic wait_line(input int sel, input logic want);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (line(sel) !== want && n < 3000);
	endtask : wait_line
	// source one byte; attention true marks a command
	task automatic send(input logic atn, input logic [7:0] d, input logic e);
		@(posedge clock);
		#1 atn_b = ~atn;
		h_nrfd_oe = 1'b0;
		h_ndac_oe = 1'b0;
		repeat (2 + lag) @(posedge clock);
		wait_line(1, 1'b1);
		#1 h_dio_oe = d;
		h_eoi_oe = e;
		repeat (2) @(posedge clock);
		#1 h_dav_oe = 1'b1;
		wait_line(2, 1'b1);
		#1 h_dav_oe = 1'b0;
		h_dio_oe = 8'h00;
		h_eoi_oe = 1'b0;
	endtask : send
	// accept one byte, then hold off the next
	task automatic recv();
		@(posedge clock);
		#1 atn_b = 1'b1;
		h_ndac_oe = 1'b1;
		h_nrfd_oe = 1'b0;
		wait_line(0, 1'b0);
		#1 h_nrfd_oe = 1'b1;
		repeat (lag) @(posedge clock);
		@(posedge clock);
		#1 h_ndac_oe = 1'b0;
		wait_line(0, 1'b1);
		#1 h_ndac_oe = 1'b1;
	endtask : recv
endmodule : gii_host_model
`default_nettype wire

/* verif/gii_instrument_interface_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module gii_instrument_interface_tb_top;
	logic clock, rst_b, ren_b, ifc_b, rx_ready, tx_end, tx_valid;
	logic addr_wr, clear_mode_wr, clear_mode_zero, trg_cmd, dav_q;
	logic [7:0] tx_data, status_byte, srq_enable, dio_b_o, rx_data;
	logic [4:0] addr_value, bus_addr;
	logic dio_b_oe, dav_b_oe, nrfd_b_oe, ndac_b_oe, eoi_b_oe, srq_b_oe;
	logic rx_end, rx_valid, tx_ready, remote, analog_select, talker;
	logic listener, dev_clear, zero_output, trigger;
	logic serial_poll, dav_b_o, nrfd_b_o, ndac_b_o, eoi_b_o, srq_b_o;
	wire logic atn_b, h_dav_oe, h_nrfd_oe, h_ndac_oe, h_eoi_oe;
	wire logic [7:0] h_dio_oe;
	wire logic [7:0] dio_w = (dio_b_oe ? dio_b_o : 8'hFF) & ~h_dio_oe;
	wire logic dav_w = (dav_b_oe ? dav_b_o : 1'b1) & ~h_dav_oe;
	wire logic nrfd_w = (nrfd_b_oe ? nrfd_b_o : 1'b1) & ~h_nrfd_oe;
	wire logic ndac_w = (ndac_b_oe ? ndac_b_o : 1'b1) & ~h_ndac_oe;
	wire logic eoi_w = (eoi_b_oe ? eoi_b_o : 1'b1) & ~h_eoi_oe;
	wire logic srq_w = srq_b_oe ? srq_b_o : 1'b1;
	logic [15:0] notes[$];
	int miscompares, checks, cycles;
	logic [31:0] seed;

	gii_instrument_interface gii_instrument_interface_inst (.clock(clock),
		.rst_b(rst_b), .atn_b(atn_b), .ifc_b(ifc_b), .ren_b(ren_b),
		.dio_b_i(dio_w), .dio_b_o(dio_b_o), .dio_b_oe(dio_b_oe),
		.dav_b_i(dav_w), .dav_b_o(dav_b_o), .dav_b_oe(dav_b_oe),
		.nrfd_b_i(nrfd_w), .nrfd_b_o(nrfd_b_o), .nrfd_b_oe(nrfd_b_oe),
		.ndac_b_i(ndac_w), .ndac_b_o(ndac_b_o), .ndac_b_oe(ndac_b_oe),
		.eoi_b_i(eoi_w), .eoi_b_o(eoi_b_o), .eoi_b_oe(eoi_b_oe),
		.srq_b_o(srq_b_o), .srq_b_oe(srq_b_oe),
		.rx_data(rx_data), .rx_end(rx_end),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
		.tx_end(tx_end), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.status_byte(status_byte), .srq_enable(srq_enable),
		.addr_wr(addr_wr), .addr_value(addr_value),
		.clear_mode_wr(clear_mode_wr), .clear_mode_zero(clear_mode_zero),
		.trg_cmd(trg_cmd), .bus_addr(bus_addr), .remote(remote),
		.analog_select(analog_select), .talker(talker), .listener(listener),
		.serial_poll(serial_poll), .dev_clear(dev_clear),
		.zero_output(zero_output),
		.trigger(trigger));

	gii_host_model gii_host_model_inst (.clock(clock), .dio_w(dio_w),
		.dav_w(dav_w), .nrfd_w(nrfd_w), .ndac_w(ndac_w), .atn_b(atn_b),
		.h_dio_oe(h_dio_oe), .h_dav_oe(h_dav_oe), .h_nrfd_oe(h_nrfd_oe),
		.h_ndac_oe(h_ndac_oe), .h_eoi_oe(h_eoi_oe));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xs
	task automatic close_out();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : close_out
	task automatic cmp_note(input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (exp !== got) begin
			miscompares++;
			$display("unexpected note at %0t: %h vs %h", $time, exp, got);
		end
	endtask : cmp_note
	task automatic cmp_level(input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (exp !== got) begin
			miscompares++;
			$display("unexpected level at %0t: %h vs %h", $time, exp, got);
		end
	endtask : cmp_level
	task automatic take(input logic [15:0] got);
		if (notes.size() == 0) cmp_note(16'hFFFF, got);
		else cmp_note(notes.pop_front(), got);
	endtask : take
	task automatic cmd(input logic [7:0] b);
		gii_host_model_inst.send(1'b1, b, 1'b0);
		repeat (3) @(posedge clock);
	endtask : cmd
	task automatic pulse(input int sel);
		@(posedge clock);
		#1 trg_cmd = (sel == 0);
		clear_mode_wr = (sel == 1);
		addr_wr = (sel == 2);
		@(posedge clock);
		#1 trg_cmd = 1'b0;
		clear_mode_wr = 1'b0;
		addr_wr = 1'b0;
		repeat (2) @(posedge clock);
	endtask : pulse
	task automatic talk(input logic [7:0] d, input logic e);
		int n;
		notes.push_back({4'h4, 3'h0, e, d});
		fork
			gii_host_model_inst.recv();
			begin
				@(posedge clock);
				#1 tx_data = d;
				tx_end = e;
				tx_valid = 1'b1;
				n = 0;
				do begin
					@(posedge clock);
					n++;
				end while (tx_ready !== 1'b1 && n < 100);
				#1 tx_valid = 1'b0;
			end
		join
	endtask : talk

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// outcome watcher
	always @(posedge clock) begin
		if (rx_valid === 1'b1) take({4'h1, 3'h0, rx_end, rx_data});
		if (dev_clear === 1'b1) take({4'h2, 11'h0, zero_output});
		if (trigger === 1'b1) take(16'h3000);
		if (dav_b_oe === 1'b1 && dav_q !== 1'b1)
			take({4'h4, 3'h0, eoi_b_oe, ~dio_b_o});
		dav_q = dav_b_oe;
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			close_out();
		end
	end
	// parser readiness wanders at random
	always @(posedge clock) begin
		#1 seed = xs(seed);
		rx_ready = seed[0] | seed[1];
	end

	initial begin
		rst_b = 1'b0; ren_b = 1'b0; ifc_b = 1'b1; rx_ready = 1'b1;
		tx_end = 1'b0; tx_valid = 1'b0; tx_data = 8'h00; addr_wr = 1'b0;
		addr_value = 5'h09; clear_mode_wr = 1'b0; clear_mode_zero = 1'b1;
		trg_cmd = 1'b0; status_byte = 8'h45; srq_enable = 8'h40;
		seed = 32'h25; miscompares = 0; checks = 0; cycles = 0; dav_q = 1'b0;
		repeat (16) @(posedge clock);
		#1 rst_b = 1'b1;
		repeat (4) @(posedge clock);
		cmp_level(8'h06, {3'h0, bus_addr});
		cmp_level(8'h01, {7'h0, analog_select});
		cmp_level(8'h00, {7'h0, srq_b_oe});
		notes.push_back(16'h2000);
		cmd(8'h14);
		cmd(8'h26);
		cmp_level(8'h01, {7'h0, listener});
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			gii_host_model_inst.lag = int'(seed[9:8]);
			notes.push_back({4'h1, 3'h0, i == 5, seed[7:0]});
			gii_host_model_inst.send(1'b0, seed[7:0], i == 5);
		end
		repeat (3) @(posedge clock);
		cmp_level(8'h01, {7'h0, remote});
		cmp_level(8'h00, {7'h0, analog_select});
		notes.push_back(16'h3000);
		cmd(8'h08);
		notes.push_back(16'h3000);
		pulse(0);
		pulse(1);
		notes.push_back(16'h2001);
		cmd(8'h04);
		cmd(8'h01);
		cmp_level(8'h00, {7'h0, remote});
		cmd(8'h46);
		cmp_level(8'h01, {7'h0, talker});
		cmp_level(8'h00, {7'h0, listener});
		for (int i = 0; i < 3; i++) begin
			seed = xs(seed);
			talk(seed[7:0], i == 2);
		end
		cmd(8'h26);
		cmp_level(8'h00, {7'h0, talker});
		cmp_level(8'h00, {7'h0, srq_b_oe});
		#1 srq_enable = 8'h41;
		repeat (3) @(posedge clock);
		cmp_level(8'h01, {7'h0, srq_b_oe});
		cmp_level(8'h00, {7'h0, srq_w});
		cmd(8'h18);
		cmp_level(8'h01, {7'h0, serial_poll});
		cmd(8'h46);
		notes.push_back(16'h4045);
		gii_host_model_inst.recv();
		cmd(8'h19);
		cmp_level(8'h00, {7'h0, serial_poll});
		cmd(8'h5F);
		cmp_level(8'h00, {7'h0, srq_b_oe});
		cmp_level(8'h00, {7'h0, talker});
		pulse(2);
		cmp_level(8'h09, {3'h0, bus_addr});
		cmd(8'h29);
		cmp_level(8'h01, {7'h0, listener});
		notes.push_back(16'h1055);
		gii_host_model_inst.send(1'b0, 8'h55, 1'b0);
		repeat (3) @(posedge clock);
		cmp_level(8'h01, {7'h0, remote});
		// going local must hand control back to the analog inputs
		#1 ren_b = 1'b1;
		repeat (2) @(posedge clock);
		cmp_level(8'h01, {7'h0, analog_select});
		cmp_level(8'h00, {7'h0, remote});
		#1 ren_b = 1'b0;
		cmd(8'h3F);
		repeat (20) @(posedge clock);
		cmp_level(8'h00, 8'(notes.size()));
		close_out();
	end
endmodule : gii_instrument_interface_tb_top
`default_nettype wire
